// ### core/lpsr_pkg.sv
// lpsr_pkg: constants and carrier types for the protection/status register block.
// assumes a 100 MHz core clock and an upstream serial slave that decodes byte transfers.
package lpsr_pkg;

    // register addresses
    localparam logic [7:0] LPSR_ADDR_FAULT_STATUS   = 8'h00;
    localparam logic [7:0] LPSR_ADDR_STATUS_2       = 8'h01;
    localparam logic [7:0] LPSR_ADDR_PROT_CONFIG    = 8'h05;

    // protection_config field positions
    localparam int LPSR_CFG_DIAG_EN_B_BIT  = 4;
    localparam int LPSR_CFG_RESERVED_BIT   = 5;
    localparam int LPSR_CFG_THERMAL_LATCH_SELECT_LATCH_BIT = 6;
    localparam int LPSR_CFG_COMP_BIT       = 7;

    // fault_status field positions
    localparam int LPSR_ST_OVERLOAD_A_BIT  = 0;
    localparam int LPSR_ST_OVERLOAD_B_BIT  = 1;
    localparam int LPSR_ST_VLOW_A_BIT      = 2;
    localparam int LPSR_ST_VLOW_B_BIT      = 3;
    localparam int LPSR_ST_PULLDOWN_OVERCURRENT_A_BIT       = 4;
    localparam int LPSR_ST_PULLDOWN_OVERCURRENT_B_BIT       = 5;
    localparam int LPSR_ST_OVERTEMP_BIT    = 6;
    localparam int LPSR_ST_UNDERVOLT_BIT   = 7;

    // reset values
    localparam logic [7:0] LPSR_PROT_CONFIG_RESET = 8'h00;
    localparam logic [7:0] LPSR_READ_DATA_RESET   = 8'h00;
    localparam logic [7:0] LPSR_UNMAPPED_READ     = 8'h00;

    // timing
    localparam int LPSR_CLK_PERIOD_PS      = 10000;
    localparam int LPSR_PDO_DEGLITCH_NS    = 1000;
    localparam int LPSR_PDO_DEGLITCH_CYC   =
        (LPSR_PDO_DEGLITCH_NS * 1000 + LPSR_CLK_PERIOD_PS - 1) / LPSR_CLK_PERIOD_PS;
    localparam int LPSR_DGL_W              = 16;

    // raw conditions from the analog monitors, synchronous to the core clock
    typedef struct packed {
        logic overload_a;
        logic overload_b;
        logic vlow_a;
        logic vlow_b;
        logic pulldown_oc_a;
        logic pulldown_oc_b;
        logic overtemp;
        logic undervolt;
    } lpsr_monitor_t;

    // register access strobes from the serial slave
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lpsr_reg_req_t;

    // supply enables and voltage-select clear toward the regulators
    typedef struct packed {
        logic enable_a;
        logic enable_b;
        logic output_voltage_select_clear;
    } lpsr_supply_ctl_t;

endpackage

// ### core/lpsr_regs.sv
// lpsr_regs: protection_config register, fault_status register and the
// thermal / overload shutdown sequencing for both supply channels.
// assumes monitor inputs and register strobes are synchronous to i_core_clk.
`timescale 1ns/1ps
`default_nettype none

module lpsr_regs #(
    parameter int DEGLITCH_CYCLES = lpsr_pkg::LPSR_PDO_DEGLITCH_CYC
) (
    // clock and reset
    input  wire logic                       i_core_clk,
    input  wire logic                       i_reset,
    // register access
    input  wire lpsr_pkg::lpsr_reg_req_t    i_reg_req,
    output logic [7:0]                      o_reg_rdata,
    // analog monitors
    input  wire lpsr_pkg::lpsr_monitor_t    i_monitor,
    // overload latch field held in the neighbouring config register
    input  wire logic                       i_overload_latch_select,
    // pulse: host has written a voltage-select field
    input  wire logic                       i_output_voltage_select_written,
    // controls toward the analog section
    output lpsr_pkg::lpsr_supply_ctl_t      o_supply_ctl,
    output logic                            o_low_current_diag_enable_b,
    output logic                            o_comp_high_esr
);
    import lpsr_pkg::*;

    typedef struct packed {
        logic [7:0]            config_q;
        logic [7:0]            rdata;
        logic [LPSR_DGL_W-1:0] dgl_a;
        logic [LPSR_DGL_W-1:0] dgl_b;
        logic                  pulldown_overcurrent_a;
        logic                  pulldown_overcurrent_b;
        logic                  thermal_latch_select_off;
        logic                  ovl_off_a;
        logic                  ovl_off_b;
        logic                  prev_fault_trip;
        logic                  output_voltage_select_clear;
    } lpsr_state_t;

    localparam logic [LPSR_DGL_W-1:0] DGL_LIMIT = LPSR_DGL_W'(DEGLITCH_CYCLES);

    lpsr_state_t state_reg;
    lpsr_state_t state_next;
    logic [7:0]  status_now;
    logic        thermal_latch_select_latch;
    logic        trip_now;

    // pull-down overcurrent deglitch counter step
    function automatic logic [LPSR_DGL_W-1:0] dgl_step(
        input logic                  raw,
        input logic [LPSR_DGL_W-1:0] cnt
    );
        if (!raw) begin
            dgl_step = '0;
        end else if (cnt < DGL_LIMIT) begin
            dgl_step = cnt + LPSR_DGL_W'(1);
        end else begin
            dgl_step = cnt;
        end
    endfunction

    // deglitched flag: raised once the counter has reached the limit
    function automatic logic dgl_flag(input logic [LPSR_DGL_W-1:0] cnt);
        dgl_flag = (cnt >= DGL_LIMIT);
    endfunction

    // shutdown hold for one fault source; a fault seen under the latch setting
    // wins over a release in the same cycle, so a trip is never lost
    function automatic logic off_step(
        input logic cur_off,
        input logic latch_sel,
        input logic fault,
        input logic sel_written
    );
        if (latch_sel && fault) begin
            off_step = 1'b1;
        end else if (!latch_sel) begin
            off_step = 1'b0;
        end else if (sel_written && !fault) begin
            off_step = 1'b0;
        end else begin
            off_step = cur_off;
        end
    endfunction

    // read multiplexer; the second status slot and unmapped addresses read zero
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input logic [7:0] status,
        input logic [7:0] cfg
    );
        case (addr)
            LPSR_ADDR_FAULT_STATUS: read_mux = status;
            LPSR_ADDR_PROT_CONFIG:  read_mux = cfg;
            default:                read_mux = LPSR_UNMAPPED_READ;
        endcase
    endfunction

    // channel output enable: off while its faults persist or while latched off
    function automatic logic chan_enable(
        input logic thermal_latch_select_off,
        input logic ovl_off,
        input logic overtemp,
        input logic overload
    );
        chan_enable = !thermal_latch_select_off && !ovl_off && !overtemp && !overload;
    endfunction

    assign thermal_latch_select_latch = state_reg.config_q[LPSR_CFG_THERMAL_LATCH_SELECT_LATCH_BIT];

    // live status image, no sticky bits so reads are free of side effects
    always_comb begin
        status_now = '0;
        status_now[LPSR_ST_OVERLOAD_A_BIT] = i_monitor.overload_a;
        status_now[LPSR_ST_OVERLOAD_B_BIT] = i_monitor.overload_b;
        status_now[LPSR_ST_VLOW_A_BIT]     = i_monitor.vlow_a;
        status_now[LPSR_ST_VLOW_B_BIT]     = i_monitor.vlow_b;
        status_now[LPSR_ST_PULLDOWN_OVERCURRENT_A_BIT]      = state_reg.pulldown_overcurrent_a;
        status_now[LPSR_ST_PULLDOWN_OVERCURRENT_B_BIT]      = state_reg.pulldown_overcurrent_b;
        status_now[LPSR_ST_OVERTEMP_BIT]   = i_monitor.overtemp;
        status_now[LPSR_ST_UNDERVOLT_BIT]  = i_monitor.undervolt;
    end

    // a latched trip fires when a fault appears under a latch setting
    assign trip_now = (thermal_latch_select_latch && i_monitor.overtemp)
                   || (i_overload_latch_select
                       && (i_monitor.overload_a || i_monitor.overload_b));

    always_comb begin
        state_next = state_reg;

        // register writes; status addresses ignore writes
        if (i_reg_req.wr && i_reg_req.addr == LPSR_ADDR_PROT_CONFIG) begin
            state_next.config_q = i_reg_req.wdata;
            state_next.config_q[LPSR_CFG_RESERVED_BIT] = 1'b0;
        end

        // register reads return data one cycle later
        if (i_reg_req.rd) begin
            state_next.rdata = read_mux(i_reg_req.addr, status_now,
                                        state_reg.config_q);
        end

        state_next.dgl_a = dgl_step(i_monitor.pulldown_oc_a, state_reg.dgl_a);
        state_next.dgl_b = dgl_step(i_monitor.pulldown_oc_b, state_reg.dgl_b);
        state_next.pulldown_overcurrent_a = dgl_flag(state_next.dgl_a);
        state_next.pulldown_overcurrent_b = dgl_flag(state_next.dgl_b);

        // latched thermal shutdown holds until the flag is gone and selects rewritten
        state_next.thermal_latch_select_off = off_step(state_reg.thermal_latch_select_off, thermal_latch_select_latch,
                                        i_monitor.overtemp, i_output_voltage_select_written);

        // overload latching works per channel in the same way
        state_next.ovl_off_a = off_step(state_reg.ovl_off_a, i_overload_latch_select,
                                        i_monitor.overload_a, i_output_voltage_select_written);
        state_next.ovl_off_b = off_step(state_reg.ovl_off_b, i_overload_latch_select,
                                        i_monitor.overload_b, i_output_voltage_select_written);

        // one pulse clears every voltage-select field on a new latched trip
        state_next.prev_fault_trip = trip_now;
        state_next.output_voltage_select_clear = trip_now && !state_reg.prev_fault_trip;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_reg.config_q        <= LPSR_PROT_CONFIG_RESET;
            state_reg.rdata           <= LPSR_READ_DATA_RESET;
            state_reg.dgl_a           <= '0;
            state_reg.dgl_b           <= '0;
            state_reg.pulldown_overcurrent_a           <= 1'b0;
            state_reg.pulldown_overcurrent_b           <= 1'b0;
            state_reg.thermal_latch_select_off       <= 1'b0;
            state_reg.ovl_off_a       <= 1'b0;
            state_reg.ovl_off_b       <= 1'b0;
            state_reg.prev_fault_trip <= 1'b0;
            state_reg.output_voltage_select_clear      <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs off while overtemp or the channel's own overload persists (auto mode) or while latched off
    always_comb begin
        o_supply_ctl            = '0;
        o_supply_ctl.enable_a   = chan_enable(state_reg.thermal_latch_select_off,
                                              state_reg.ovl_off_a,
                                              i_monitor.overtemp,
                                              i_monitor.overload_a);
        o_supply_ctl.enable_b   = chan_enable(state_reg.thermal_latch_select_off,
                                              state_reg.ovl_off_b,
                                              i_monitor.overtemp,
                                              i_monitor.overload_b);
        o_supply_ctl.output_voltage_select_clear = state_reg.output_voltage_select_clear;
    end
    assign o_reg_rdata             = state_reg.rdata;
    assign o_low_current_diag_enable_b = state_reg.config_q[LPSR_CFG_DIAG_EN_B_BIT];
    assign o_comp_high_esr         = state_reg.config_q[LPSR_CFG_COMP_BIT];

endmodule

`default_nettype wire

// ### verification/lpsr_regs_assertions.sv
// checker bound to lpsr_regs: register and supply-control timing.
// assumes the lpsr_pkg types and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lpsr_regs_assertions
    import lpsr_pkg::*;
#(
    parameter int DEGLITCH_CYCLES = 4
) (
    input wire logic             i_core_clk,
    input wire logic             i_reset,
    input wire lpsr_reg_req_t    i_reg_req,
    input wire logic [7:0]       o_reg_rdata,
    input wire lpsr_monitor_t    i_monitor,
    input wire logic             i_overload_latch_select,
    input wire logic             i_output_voltage_select_written,
    input wire lpsr_supply_ctl_t o_supply_ctl,
    input wire logic             o_low_current_diag_enable_b,
    input wire logic             o_comp_high_esr
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    wire logic       st_rd  = i_reg_req.rd && i_reg_req.addr == LPSR_ADDR_FAULT_STATUS;
    wire logic       cfg_wr = i_reg_req.wr && i_reg_req.addr == LPSR_ADDR_PROT_CONFIG;
    wire logic [7:0] st_exp = {i_monitor.undervolt, i_monitor.overtemp, 2'b00,
        i_monitor.vlow_b, i_monitor.vlow_a, i_monitor.overload_b, i_monitor.overload_a};
    int pdo_run_a;
    int pdo_run_b;
    always_ff @(posedge i_core_clk) begin
        pdo_run_a <= (i_reset || !i_monitor.pulldown_oc_a) ? 0
                   : ((pdo_run_a < DEGLITCH_CYCLES) ? pdo_run_a + 1 : pdo_run_a);
        pdo_run_b <= (i_reset || !i_monitor.pulldown_oc_b) ? 0
                   : ((pdo_run_b < DEGLITCH_CYCLES) ? pdo_run_b + 1 : pdo_run_b);
    end
    wire logic [1:0] pdo_exp = {pdo_run_b >= DEGLITCH_CYCLES, pdo_run_a >= DEGLITCH_CYCLES};
    property p_pdo; st_rd |=> o_reg_rdata[5:4] == $past(pdo_exp); endproperty
    a_pdo: assert property (p_pdo) else $error("pulldown flag timing wrong");
    property p_status; st_rd |=> (o_reg_rdata & 8'hCF) == $past(st_exp); endproperty
    a_status: assert property (p_status) else $error("status read mismatch");
    property p_pdo_low; (!i_monitor.pulldown_oc_a)[*3] ##0 st_rd |=> !o_reg_rdata[4]; endproperty
    a_pdo_low: assert property (p_pdo_low) else $error("pulldown flag without cause");
    property p_rd_hold; !i_reg_req.rd |=> $stable(o_reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_cfg; cfg_wr |=> o_comp_high_esr == $past(i_reg_req.wdata[7])
        && o_low_current_diag_enable_b == $past(i_reg_req.wdata[4]); endproperty
    a_cfg: assert property (p_cfg) else $error("config write not applied");
    property p_cfg_keep; !cfg_wr |=> $stable({o_comp_high_esr, o_low_current_diag_enable_b});
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("config changed");
    property p_ot; i_monitor.overtemp |-> !o_supply_ctl.enable_a && !o_supply_ctl.enable_b;
    endproperty
    a_ot: assert property (p_ot) else $error("enabled during overtemp");
    property p_ol; !(i_monitor.overload_a && o_supply_ctl.enable_a)
        && !(i_monitor.overload_b && o_supply_ctl.enable_b); endproperty
    a_ol: assert property (p_ol) else $error("enabled during overload");
    property p_vclr; o_supply_ctl.output_voltage_select_clear |=> !o_supply_ctl.output_voltage_select_clear; endproperty
    a_vclr: assert property (p_vclr) else $error("select clear too long");
endmodule
bind lpsr_regs lpsr_regs_assertions #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) u_lpsr_regs_assertions (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_req(i_reg_req),
    .o_reg_rdata(o_reg_rdata), .i_monitor(i_monitor),
    .i_overload_latch_select(i_overload_latch_select), .i_output_voltage_select_written(i_output_voltage_select_written),
    .o_supply_ctl(o_supply_ctl), .o_low_current_diag_enable_b(o_low_current_diag_enable_b),
    .o_comp_high_esr(o_comp_high_esr));
`default_nettype wire

// ### verification/lpsr_host.sv
// lpsr_host: register host model driving byte strobes.
// assumes requests start at least two cycles apart.
`timescale 1ns/1ps
`default_nettype none
module lpsr_host
    import lpsr_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    output var lpsr_reg_req_t o_req,
    output logic            o_output_voltage_select_written
);
    initial begin
        o_req = '0;
        o_output_voltage_select_written = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & 8'hDF};
        @(posedge i_core_clk);
        #1;
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_core_clk);
        #1;
        d = i_rdata;
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask
    // one-cycle select-rewritten strobe, issued whether or not a fault is present
    task automatic output_voltage_select();
        @(posedge i_core_clk);
        #1;
        o_output_voltage_select_written = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_output_voltage_select_written = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// testbench: host model and monitor stimulus around lpsr_regs.
// assumes the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lpsr_pkg::*;
    logic clk, rst, ols, output_voltage_select_wr, diag_b, comp;
    logic [7:0] rdata, d;
    lpsr_reg_req_t req;
    lpsr_monitor_t mon;
    lpsr_supply_ctl_t sup;
    int bad_count, num_checks, vclr;
    int sbits[6] = '{0, 1, 2, 3, 6, 7};
    lpsr_regs #(.DEGLITCH_CYCLES(4)) u_lpsr_regs (.i_core_clk(clk), .i_reset(rst),
        .i_reg_req(req), .o_reg_rdata(rdata), .i_monitor(mon), .i_overload_latch_select(ols),
        .i_output_voltage_select_written(output_voltage_select_wr), .o_supply_ctl(sup), .o_low_current_diag_enable_b(diag_b),
        .o_comp_high_esr(comp));
    lpsr_host u_lpsr_host (.i_core_clk(clk), .i_rdata(rdata), .o_req(req),
        .o_output_voltage_select_written(output_voltage_select_wr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (sup.output_voltage_select_clear === 1'b1) vclr++;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        u_lpsr_host.rd(a, d);
        chk(d, e);
    endtask
    task automatic t_cfg();
        rdc(LPSR_ADDR_PROT_CONFIG, 8'h00);
        u_lpsr_host.wr(LPSR_ADDR_PROT_CONFIG, 8'hFF);
        rdc(LPSR_ADDR_PROT_CONFIG, 8'hDF);
        chk({6'h00, diag_b, comp}, 8'h03);
        u_lpsr_host.wr(LPSR_ADDR_PROT_CONFIG, 8'h80);
        cyc(1);
        chk({6'h00, diag_b, comp}, 8'h01);
        $display("cfg done");
    endtask
    task automatic t_status();
        foreach (sbits[i]) begin
            mon = lpsr_monitor_t'(8'h80 >> sbits[i]);
            rdc(LPSR_ADDR_FAULT_STATUS, 8'h01 << sbits[i]);
            rdc(LPSR_ADDR_FAULT_STATUS, 8'h01 << sbits[i]);
        end
        mon = '0;
        u_lpsr_host.wr(LPSR_ADDR_FAULT_STATUS, 8'hFF);
        rdc(LPSR_ADDR_FAULT_STATUS, 8'h00);
        rdc(8'h07, 8'h00);
        $display("status done");
    endtask
    task automatic t_pdo();
        mon.pulldown_oc_a = 1'b1;
        cyc(2);
        mon.pulldown_oc_a = 1'b0;
        cyc(3);
        rdc(LPSR_ADDR_FAULT_STATUS, 8'h00);
        mon.pulldown_oc_a = 1'b1;
        mon.pulldown_oc_b = 1'b1;
        cyc(8);
        rdc(LPSR_ADDR_FAULT_STATUS, 8'h30);
        mon = '0;
        cyc(3);
        rdc(LPSR_ADDR_FAULT_STATUS, 8'h00);
        $display("pulldown done");
    endtask
    task automatic trip(input logic lat, input logic [7:0] sel, input logic [7:0] e_on);
        vclr = 0;
        mon = lpsr_monitor_t'(sel);
        cyc(3);
        chk({6'h00, sup.enable_a, sup.enable_b}, e_on);
        u_lpsr_host.output_voltage_select();
        chk({6'h00, sup.enable_a, sup.enable_b}, e_on);
        mon = '0;
        cyc(3);
        chk({6'h00, sup.enable_a, sup.enable_b}, lat ? e_on : 8'h03);
        u_lpsr_host.output_voltage_select();
        cyc(1);
        chk({6'h00, sup.enable_a, sup.enable_b}, 8'h03);
        chk(8'(vclr), {7'h00, lat});
    endtask
    task automatic t_prot();
        u_lpsr_host.wr(LPSR_ADDR_PROT_CONFIG, 8'h40);
        trip(1'b1, 8'h02, 8'h00);
        u_lpsr_host.wr(LPSR_ADDR_PROT_CONFIG, 8'h00);
        trip(1'b0, 8'h02, 8'h00);
        ols = 1'b1;
        trip(1'b1, 8'h80, 8'h01);
        ols = 1'b0;
        trip(1'b0, 8'h40, 8'h02);
        $display("protection done");
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        bad_count = 0;
        num_checks = 0;
        vclr = 0;
        mon = '0;
        ols = 1'b0;
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        t_cfg();
        t_status();
        t_pdo();
        t_prot();
        end_of_test();
    end
    initial begin
        #50000;
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
